// ===== csfb_consts.vh
// register offsets, field positions and reset values of the status and flag bank
`ifndef CSFB_CONSTS_VH
`define CSFB_CONSTS_VH
`define CSFB_ADDR_W 8
`define CSFB_OFF_LIVE_CHARGE 8'h00
`define CSFB_OFF_LIVE_FAULT 8'h01
`define CSFB_OFF_LIVE_COMP 8'h02
`define CSFB_OFF_EVT_CHARGE 8'h03
`define CSFB_OFF_EVT_FAULT 8'h04
`define CSFB_FLAG_RESET 8'h00
`define CSFB_UNMAPPED_DATA 8'h00
`define CSFB_BIT_TAPER 6
`define CSFB_BIT_DONE 5
`define CSFB_BIT_IINLIM 4
`define CSFB_BIT_PPM 3
`define CSFB_BIT_VINM 2
`define CSFB_BIT_THERM 1
`define CSFB_BIT_PGOOD 0
`define CSFB_BIT_OVP 7
`define CSFB_BIT_OCP 5
`define CSFB_BIT_UVLO 4
`define CSFB_BIT_COLD 3
`define CSFB_BIT_COOL 2
`define CSFB_BIT_WARM 1
`define CSFB_BIT_HOT 0
`define CSFB_BIT_CMP1 6
`define CSFB_BIT_CMP2 5
`define CSFB_BIT_CMP3 4
`define CSFB_BIT_TSOPEN 0
`endif

// ===== csfb_status_flag_bank.v
// status and clear-on-read event flag register bank of a linear charger
// Notes on behaviour
// - read-only live register at 0x0, bit7 reserved
// - bit6 shows constant-voltage taper charging
// - bit5 shows charge done
// - bit4 shows input current limit active
// - bits3,2 show power-path and input-voltage management
// - bit1 shows thermal regulation active
// - bit0 shows input power good window
// - 0x1 bit7 input overvoltage, bit6 reserved
// - bit5 shows battery overcurrent protection
// - bit4 shows battery below lockout level
// - bits3,0 show thermistor cold and hot
// - bit2 shows thermistor cool region
// - bit1 shows thermistor warm region
// - 0x2 bits6..4 show comparator one..three results
// - 0x2 bit0 thermistor open, others reserved
// - 0x3 flags reset zero, clear on read
// - bit6 latches taper mode entry
// - bit5 latches charge termination
// - bits4..1 latch regulation loop activity
// - bit0 latches any power-good change
// - 0x4 flags reset zero, clear on read
`timescale 1ns/1ps
`include "csfb_consts.vh"
module csfb_status_flag_bank #(
	parameter ADDR_W = `CSFB_ADDR_W
) (
	input wire i_sys_clk,
	input wire i_srst,
	input wire i_taper_phase_live,
	input wire i_charge_done_live,
	input wire i_input_current_limit_live,
	input wire i_power_path_mgmt_live,
	input wire i_input_voltage_mgmt_live,
	input wire i_thermal_regulation_live,
	input wire i_input_power_good_live,
	input wire i_input_overvoltage_live,
	input wire i_battery_overcurrent_live,
	input wire i_battery_undervoltage_live,
	input wire i_thermistor_cold_live,
	input wire i_thermistor_cool_live,
	input wire i_thermistor_warm_live,
	input wire i_thermistor_hot_live,
	input wire i_adc_compare_one_live,
	input wire i_adc_compare_two_live,
	input wire i_adc_compare_three_live,
	input wire i_thermistor_open_live,
	input wire i_rd_en,
	input wire [ADDR_W-1:0] i_rd_addr,
	output reg [7:0] o_rd_data,
	output reg o_rd_valid
);

	// register map as the host reads it, one line per bit
	// 0x00 live charge, read only, follows the inputs one edge late
	//   7 reserved, reads 0
	//   6 constant-voltage taper charging
	//   5 charge done
	//   4 input current limit loop
	//   3 power-path management loop
	//   2 input-voltage management loop
	//   1 thermal regulation loop
	//   0 input power good window
	// 0x01 live faults and thermistor regions, read only
	//   7 input overvoltage
	//   6 reserved, reads 0
	//   5 battery overcurrent
	//   4 battery below lockout level
	//   3 thermistor cold, charging suspended
	//   2 thermistor cool, current reduced
	//   1 thermistor warm, voltage reduced
	//   0 thermistor hot, charging suspended
	// 0x02 live comparators, read only
	//   7 reserved, reads 0
	//   6 adc comparator one
	//   5 adc comparator two
	//   4 adc comparator three
	//   3..1 reserved, read 0
	//   0 thermistor open
	// 0x03 charge event flags, cleared by a read
	//   7 reserved, never latches
	//   6..1 latch on entry of the matching live condition
	//   0 latches on either edge of power good
	// 0x04 fault event flags, cleared by a read
	//   bits follow the 0x01 layout, latched while the level is high
	//   6 reserved, never latches
	// other offsets read 0 and have no side effect

	// timing seen from the read port
	//   a read is taken at the edge where i_rd_en is high
	//   o_rd_valid pulses one cycle after that edge
	//   o_rd_data holds until the next read is taken
	//   live words lag their inputs by one edge
	//   a flag sets at the same edge its live word updates
	//   a flag read returns the value held before the clear
	//   an event at the clear edge survives, so nothing is lost
	//   the host may read every cycle, no gap needed
	// limits
	//   conditions shorter than one clock are not seen
	//   inputs must already be synchronous to i_sys_clk
	//   reserved bits are forced low, whatever the inputs
	//   unmapped offsets leave every flag untouched

	// which bits of each word carry a condition
	localparam [7:0] CHARGE_USED = 8'h7F; // bit7 reserved
	localparam [7:0] FAULT_USED = 8'hBF; // bit6 reserved
	localparam [7:0] COMP_USED = 8'h71; // bit7 and bits3..1 reserved

	// edge kinds of the charge event word
	localparam [7:0] EDGE_RISE = 8'h7E; // loop flags latch on entry
	localparam [7:0] EDGE_BOTH = 8'h01; // power good latches both ways
	// reset and idle read values
	localparam [7:0] FLAG_RESET = `CSFB_FLAG_RESET;
	localparam [7:0] RD_IDLE = `CSFB_UNMAPPED_DATA;
	localparam NUM_BITS = 8;

	// registered live words as the host sees them
	reg [7:0] live_status_charge;
	reg [7:0] live_status_fault_temp;
	reg [7:0] live_status_comparator;
	// previous live sample for edge detection
	reg [7:0] prev_charge;
	// sticky flag words, one cell per bit in the loop below
	wire [7:0] event_flags_charge;
	wire [7:0] event_flags_fault_temp;
	// combinational next values
	reg [7:0] next_live_charge;
	reg [7:0] next_live_fault;
	reg [7:0] next_live_comp;
	reg [7:0] evt_charge;
	reg [7:0] evt_fault;
	reg [7:0] next_rd_data;
	// address decode and clear strobes
	reg hit_live_charge;
	reg hit_live_fault;
	reg hit_live_comp;
	reg hit_evt_charge;
	reg hit_evt_fault;
	reg clr_charge;
	reg clr_fault;
	genvar gi;

	// charge word from the loop and phase inputs
	always @* begin
		next_live_charge = 8'h00;
		next_live_charge[`CSFB_BIT_TAPER] = i_taper_phase_live;
		next_live_charge[`CSFB_BIT_DONE] = i_charge_done_live;
		next_live_charge[`CSFB_BIT_IINLIM] = i_input_current_limit_live;
		next_live_charge[`CSFB_BIT_PPM] = i_power_path_mgmt_live;
		next_live_charge[`CSFB_BIT_VINM] = i_input_voltage_mgmt_live;
		next_live_charge[`CSFB_BIT_THERM] = i_thermal_regulation_live;
		next_live_charge[`CSFB_BIT_PGOOD] = i_input_power_good_live;
	end

	// fault and thermistor word
	always @* begin
		next_live_fault = 8'h00;
		next_live_fault[`CSFB_BIT_OVP] = i_input_overvoltage_live;
		next_live_fault[`CSFB_BIT_OCP] = i_battery_overcurrent_live;
		next_live_fault[`CSFB_BIT_UVLO] = i_battery_undervoltage_live;
		next_live_fault[`CSFB_BIT_COLD] = i_thermistor_cold_live;
		next_live_fault[`CSFB_BIT_HOT] = i_thermistor_hot_live;
		next_live_fault[`CSFB_BIT_COOL] = i_thermistor_cool_live;
		next_live_fault[`CSFB_BIT_WARM] = i_thermistor_warm_live;
	end

	// comparator and thermistor-open word
	always @* begin
		next_live_comp = 8'h00;
		next_live_comp[`CSFB_BIT_CMP1] = i_adc_compare_one_live;
		next_live_comp[`CSFB_BIT_CMP2] = i_adc_compare_two_live;
		next_live_comp[`CSFB_BIT_CMP3] = i_adc_compare_three_live;
		next_live_comp[`CSFB_BIT_TSOPEN] = i_thermistor_open_live;
	end

	// charge events against the previous live sample
	always @* begin
		evt_charge = (next_live_charge & ~prev_charge) & EDGE_RISE;
		evt_charge = evt_charge | ((next_live_charge ^ prev_charge) & EDGE_BOTH);
	end

	// fault events follow the level
	always @* begin
		evt_fault = next_live_fault & FAULT_USED; // reserved bit6 never latches
	end

	// address decode, one hit per register
	always @* begin
		hit_live_charge = (i_rd_addr == `CSFB_OFF_LIVE_CHARGE);
		hit_live_fault = (i_rd_addr == `CSFB_OFF_LIVE_FAULT);
		hit_live_comp = (i_rd_addr == `CSFB_OFF_LIVE_COMP);
		hit_evt_charge = (i_rd_addr == `CSFB_OFF_EVT_CHARGE);
		hit_evt_fault = (i_rd_addr == `CSFB_OFF_EVT_FAULT);
		clr_charge = i_rd_en && hit_evt_charge;
		clr_fault = i_rd_en && hit_evt_fault;
	end

	// read mux, flag words taken before the clear lands
	always @* begin
		next_rd_data = RD_IDLE;
		if (hit_live_charge) begin
			next_rd_data = live_status_charge;
		end
		if (hit_live_fault) begin
			next_rd_data = live_status_fault_temp;
		end
		if (hit_live_comp) begin
			next_rd_data = live_status_comparator;
		end
		if (hit_evt_charge) begin
			next_rd_data = event_flags_charge; // value before clearing
		end
		if (hit_evt_fault) begin
			next_rd_data = event_flags_fault_temp;
		end
	end

	// charge live register
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			live_status_charge <= 8'h00;
		end else begin
			live_status_charge <= next_live_charge & CHARGE_USED;
		end
	end

	// fault live register
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			live_status_fault_temp <= 8'h00;
		end else begin
			live_status_fault_temp <= next_live_fault & FAULT_USED;
		end
	end

	// comparator live register
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			live_status_comparator <= 8'h00;
		end else begin
			live_status_comparator <= next_live_comp & COMP_USED;
		end
	end

	// edge history of the charge word
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			prev_charge <= 8'h00;
		end else begin
			prev_charge <= next_live_charge;
		end
	end

	// one sticky cell per bit of each flag word
	generate
		for (gi = 0; gi < NUM_BITS; gi = gi + 1) begin : g_flag_bit
			reg flag_charge;
			reg flag_fault;

			// charge cell: an event sets, a read clears, the set wins
			always @(posedge i_sys_clk) begin
				if (i_srst) begin
					flag_charge <= FLAG_RESET[gi];
				end else if (evt_charge[gi]) begin
					flag_charge <= 1'b1;
				end else if (clr_charge) begin
					flag_charge <= 1'b0;
				end
			end

			// fault cell, same priority
			always @(posedge i_sys_clk) begin
				if (i_srst) begin
					flag_fault <= FLAG_RESET[gi];
				end else if (evt_fault[gi]) begin
					flag_fault <= 1'b1;
				end else if (clr_fault) begin
					flag_fault <= 1'b0;
				end
			end

			// drive the flag words
			assign event_flags_charge[gi] = flag_charge;
			assign event_flags_fault_temp[gi] = flag_fault;
		end
	endgenerate

	// read data, held until the next read
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_en) begin
			o_rd_data <= next_rd_data;
		end
	end

	// read valid, one cycle per taken read
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
		end
	end

endmodule // csfb_status_flag_bank

// ===== csfb_checker.sv
// read port assertions for the status and flag bank
`timescale 1ns/1ps
module csfb_checker (
	input wire i_sys_clk,
	input wire i_srst,
	input wire i_taper_phase_live,
	input wire i_input_power_good_live,
	input wire i_rd_en,
	input wire [7:0] i_rd_addr,
	input wire [7:0] o_rd_data,
	input wire o_rd_valid
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// a live edge, then a flag read two edges later
	// no flag read in between, which would clear the flag early
	sequence s_taper_rd;
		$rose(i_taper_phase_live) ##1 !(i_rd_en && i_rd_addr == 8'h03) ##1 i_rd_en && i_rd_addr == 8'h03;
	endsequence
	sequence s_pg_rd;
		!$past(i_srst) && $changed(i_input_power_good_live) ##1 !(i_rd_en && i_rd_addr == 8'h03)
			##1 i_rd_en && i_rd_addr == 8'h03;
	endsequence
	a_read_answered: assert property (i_rd_en |=> o_rd_valid) else $error("no answer");
	a_valid_caused: assert property (o_rd_valid |-> $past(i_rd_en)) else $error("stray answer");
	a_data_holds: assert property (!o_rd_valid |-> $stable(o_rd_data)) else $error("data moved");
	a_msb_reserved: assert property (o_rd_valid && $past(i_rd_addr) inside {8'h00, 8'h02, 8'h03} |-> !o_rd_data[7]) else $error("bit 7 set");
	a_six_reserved: assert property (o_rd_valid && $past(i_rd_addr) inside {8'h01, 8'h04} |-> !o_rd_data[6]) else $error("bit 6 set");
	a_comp_reserved: assert property (o_rd_valid && $past(i_rd_addr) == 8'h02 |-> o_rd_data[3:1] == 3'h0) else $error("bits 3:1 set");
	a_live_bits: assert property (o_rd_valid && $past(i_rd_addr) == 8'h00 && !$past(i_srst, 2)
		|-> o_rd_data[6] == $past(i_taper_phase_live, 2) && o_rd_data[0] == $past(i_input_power_good_live, 2))
		else $error("live bits wrong");
	a_taper_flag: assert property (s_taper_rd |=> o_rd_data[6]) else $error("taper flag lost");
	a_pgood_flag: assert property (s_pg_rd |=> o_rd_data[0]) else $error("power good flag lost");
endmodule // csfb_checker
bind csfb_status_flag_bank csfb_checker u_chk (.i_sys_clk, .i_srst, .i_taper_phase_live, .i_input_power_good_live, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid);

// ===== csfb_host_model.sv
// host model issuing single-byte register reads
`timescale 1ns/1ps
module csfb_host_model (
	input wire i_clk,
	input wire i_valid,
	output logic o_rd_en = 1'h0,
	output logic [7:0] o_rd_addr = 8'h00
);
	// strobe one cycle, then wait a bounded time for the answer
	task automatic rd(input logic [7:0] a, output logic ok);
		o_rd_en <= 1'h1;
		o_rd_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'h0;
		o_rd_addr <= ~a; // address no longer qualified
		ok = 1'h0;
		for (int n = 0; n < 3 && !ok; n++) begin
			@(posedge i_clk);
			ok = (i_valid === 1'h1);
		end
	endtask
endmodule // csfb_host_model

// ===== csfb_status_flag_bank_bench.sv
// self-checking bench for the status and flag bank
`timescale 1ns/1ps
module csfb_status_flag_bank_bench;
	logic i_sys_clk = 1'h0, i_srst = 1'h1, i_rd_en, o_rd_valid, ok;
	logic [7:0] i_rd_addr, o_rd_data;
	logic [17:0] lv = 18'h00000;
	int num_errors = 0, comparisons = 0;
	always #12.5 i_sys_clk = ~i_sys_clk;
	csfb_host_model u_host (.i_clk(i_sys_clk), .i_valid(o_rd_valid), .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr));
	csfb_status_flag_bank u_dut (.i_sys_clk, .i_srst, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid,
		.i_taper_phase_live(lv[17]), .i_charge_done_live(lv[16]), .i_input_current_limit_live(lv[15]),
		.i_power_path_mgmt_live(lv[14]), .i_input_voltage_mgmt_live(lv[13]), .i_thermal_regulation_live(lv[12]),
		.i_input_power_good_live(lv[11]), .i_input_overvoltage_live(lv[10]), .i_battery_overcurrent_live(lv[9]),
		.i_battery_undervoltage_live(lv[8]), .i_thermistor_cold_live(lv[7]), .i_thermistor_cool_live(lv[6]),
		.i_thermistor_warm_live(lv[5]), .i_thermistor_hot_live(lv[4]), .i_adc_compare_one_live(lv[3]),
		.i_adc_compare_two_live(lv[2]), .i_adc_compare_three_live(lv[1]), .i_thermistor_open_live(lv[0]));
	// compare one byte
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// read a register and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, ok);
		if (!ok) begin
			num_errors++;
			report_and_stop();
		end
		chk(e, o_rd_data);
	endtask
	// drive live levels and let two edges pass
	task automatic set_lv(input logic [17:0] v);
		lv <= v;
		repeat (2) @(posedge i_sys_clk);
	endtask
	task automatic t_reset();
		rc(8'h03, 8'h00);
		rc(8'h04, 8'h00);
		rc(8'h05, 8'h00);
	endtask
	task automatic t_flags();
		set_lv(18'h3FFF0);
		rc(8'h03, 8'h7F);
		rc(8'h03, 8'h00);
		rc(8'h04, 8'hBF);
		set_lv(18'h00000);
		rc(8'h03, 8'h01);
		rc(8'h04, 8'hBF);
		rc(8'h04, 8'h00);
		lv[11] <= 1'h1;
		rc(8'h03, 8'h00);
		rc(8'h03, 8'h01);
	endtask
	task automatic t_live(input logic [17:0] v);
		set_lv(v);
		rc(8'h00, {1'h0, v[17:11]});
		rc(8'h01, {v[10], 1'h0, v[9:4]});
		rc(8'h02, {1'h0, v[3:1], 3'h0, v[0]});
	endtask
	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 1'h0;
		@(posedge i_sys_clk);
		t_reset();
		t_flags();
		t_live(18'h2AAAA);
		t_live(18'h15555);
		t_live(18'h3FFFF);
		report_and_stop();
	end
endmodule // csfb_status_flag_bank_bench
